/* File: logic/mwcd_params.svh */
// Named constants for the microword control decoder: field positions,
// widths and reset values. Definitions only, no logic.
`ifndef MWCD_PARAMS_SVH
`define MWCD_PARAMS_SVH
`define MWCD_WORD_W 96
`define MWCD_BIT_ROUTE_B 95
`define MWCD_BIT_Z_TO_Z1 92
`define MWCD_BIT_CC_GATE 91
`define MWCD_BIT_BYTE_MODE 90
`define MWCD_ALU_HI 89
`define MWCD_ALU_LO 78
`define MWCD_BIT_TREG_DRIVE 77
`define MWCD_BIT_TREG_LOAD 76
`define MWCD_BIT_CNT_EN 75
`define MWCD_BIT_CNT_UP 74
`define MWCD_BIT_PC_OFF 73
`define MWCD_BIT_PC_TO_Y 72
`define MWCD_BIT_MAR_LOAD 71
`define MWCD_BIT_D_LOAD 70
`define MWCD_BIT_Z1_TO_I 69
`define MWCD_BIT_Z0_DRIVE_N 68
`define MWCD_BIT_ROM_SEL 47
`define MWCD_BIT_IO_LOAD 46
`define MWCD_BIT_SHIFT_EN 43
`define MWCD_CTL_HI 42
`define MWCD_CTL_LO 35
`define MWCD_NAC_HI 19
`define MWCD_NAC_LO 16
`define MWCD_JMP_HI 11
`define MWCD_JMP_LO 0
`define MWCD_CNT_HI 14
`define MWCD_CNT_LO 7
`define MWCD_IR_F1_HI 7
`define MWCD_IR_F1_LO 4
`define MWCD_IR_F2_HI 3
`define MWCD_IR_F2_LO 0
`define MWCD_ZERO_WORD 96'h0
`define MWCD_ZERO16 16'h0
`define MWCD_ZERO8 8'h0
`define MWCD_CNT_STEP 8'h01
`endif

/* File: logic/mwcd_pkg.sv */
// Types shared by the microword control decoder files.
// Assumes mwcd_params.svh on the include path.
`default_nettype none
`include "mwcd_params.svh"
package mwcd_pkg;
    typedef logic [`MWCD_WORD_W-1:0] mwcd_word_t;
    typedef logic [15:0] mwcd_data_t;
    typedef enum logic {MWCD_DIR_TO_MAR, MWCD_DIR_TO_Y} mwcd_dir_e;
endpackage
`default_nettype wire

/* File: logic/mwcd_ir_counter.sv */
// Instruction register with its register-address counter field.
// Assumes one clock, asynchronous active-low reset, synchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module mwcd_ir_counter
    import mwcd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Controls
    input wire logic i_load,
    input wire logic i_count_en,
    input wire logic i_count_up,
    input wire mwcd_data_t i_z1,
    // Instruction register
    output mwcd_data_t o_ireg
);
    logic [7:0] field;

    assign field = o_ireg[`MWCD_CNT_HI:`MWCD_CNT_LO];

    // Load wins over counting; a fresh instruction supersedes the step
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ireg <= `MWCD_ZERO16;
        end else if (i_load) begin
            o_ireg <= i_z1;
        end else if (i_count_en) begin
            o_ireg[`MWCD_CNT_HI:`MWCD_CNT_LO] <= i_count_up ? field + `MWCD_CNT_STEP
                                                           : field - `MWCD_CNT_STEP;
        end
    end
endmodule // mwcd_ir_counter
`default_nettype wire

/* File: logic/mwcd_decode.sv */
// Microword control decoder: pipeline register and datapath decode.
// Assumes the microword arrives from the control store once per cycle,
// and that all datapath buses are outside; three-state drive is shown
// as enables, so no bus is resolved here.
//
// Notes on behaviour
// - Bit 91 gates condition codes; one forces unconditional sequencing.
// - Bits 19..16 are the next-address instruction code.
// - Bits 11..0 are the branch target address.
// - With bit 47, control bits 42..39 address B, 38..35 address A.
// - Bit 46 loads control bits into the I/O control register.
// - Bit 43 applies low five control bits as shift controls.
// - Bit 95 routes the second register field to B address.
// - Bit 92 copies Z into Z1 at cycle start.
// - Bit 90 low: word operation; high: low byte only.
// - Byte mode blocks upper slice write enable and Y outputs.
// - Bits 89..78 drive ALU source, output enables and function.
// - Bit 77 drives transfer register onto DA bus.
// - Bit 76 loads transfer register from Y bus.
// - Bit 75 enables the instruction register counter field.
// - Bit 74 high increments, low decrements the counter.
// - Bit 73 high disables program counter transceivers.
// - Bit 72 high passes counter data to Y, low to address.
// - Byte mode disables low eight transceiver bits.
// - Bit 71 loads the memory address register.
// - Bit 70 loads the data register from Y.
// - Bit 69 moves Z1 into the 16-bit instruction register.
// - Bit 68 low drives Z0 onto DA.
// - The control word is 96 bits, numbered 95 down to 0.
`timescale 1ns/1ps
`default_nettype none
module mwcd_decode
    import mwcd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Microword from control store
    input wire mwcd_word_t i_microword,
    // Datapath inputs
    input wire mwcd_data_t i_y_bus,
    input wire mwcd_data_t i_z_prefetch,
    input wire mwcd_data_t i_pc_data,
    // Sequencer controls
    output logic o_cond_code_gate,
    output logic [3:0] o_next_addr_code,
    output logic [11:0] o_jump_addr,
    // ALU controls
    output logic [3:0] o_alu_a_addr,
    output logic [3:0] o_alu_b_addr,
    output logic o_byte_mode,
    output logic o_upper_we_block,
    output logic o_upper_y_off,
    output logic o_alu_source_select,
    output logic o_alu_y_output_en,
    output logic o_alu_b_output_en,
    output logic [8:0] o_alu_func,
    // Control byte users
    output logic [7:0] o_io_ctl,
    output logic o_shift_link_strobe,
    output logic [4:0] o_shift_link_ctl,
    // Datapath registers and drives
    output mwcd_data_t o_transfer_reg,
    output logic o_transfer_reg_drive,
    output logic o_z0_to_da_drive,
    output mwcd_data_t o_z1,
    output mwcd_data_t o_ireg,
    output mwcd_data_t o_memory_address_reg,
    output mwcd_data_t o_data_reg,
    // Program counter unit transceivers, output enables low when driving
    output logic o_pc_hi_oe_n,
    output logic o_pc_lo_oe_n,
    output mwcd_dir_e o_pc_dir
);
    mwcd_word_t mw;
    logic [7:0] ctl;
    logic [15:0] mar_src;

    // Pipeline register: decode sees a stable word all cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mw <= `MWCD_ZERO_WORD;
        end else begin
            mw <= i_microword;
        end
    end

    assign ctl = mw[`MWCD_CTL_HI:`MWCD_CTL_LO];

    // Registered straight-through fields, captured at the same edge as the pipeline
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cond_code_gate <= 1'b0;
            o_next_addr_code <= 4'h0;
            o_jump_addr <= 12'h000;
            o_alu_source_select <= 1'b0;
            o_alu_y_output_en <= 1'b0;
            o_alu_b_output_en <= 1'b0;
            o_alu_func <= 9'h000;
        end else begin
            o_cond_code_gate <= i_microword[`MWCD_BIT_CC_GATE];
            o_next_addr_code <= i_microword[`MWCD_NAC_HI:`MWCD_NAC_LO];
            o_jump_addr <= i_microword[`MWCD_JMP_HI:`MWCD_JMP_LO];
            {o_alu_source_select, o_alu_y_output_en, o_alu_b_output_en, o_alu_func}
                <= i_microword[`MWCD_ALU_HI:`MWCD_ALU_LO];
        end
    end

    // Register addresses: control byte when selected, else instruction fields
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_alu_a_addr <= 4'h0;
            o_alu_b_addr <= 4'h0;
        end else if (i_microword[`MWCD_BIT_ROM_SEL]) begin
            o_alu_b_addr <= i_microword[`MWCD_CTL_HI:`MWCD_CTL_HI-3];
            o_alu_a_addr <= i_microword[`MWCD_CTL_LO+3:`MWCD_CTL_LO];
        end else begin
            // Second field routed to B when asked; else the first field
            if (i_microword[`MWCD_BIT_ROUTE_B]) begin
                o_alu_b_addr <= o_ireg[`MWCD_IR_F2_HI:`MWCD_IR_F2_LO];
            end else begin
                o_alu_b_addr <= o_ireg[`MWCD_IR_F1_HI:`MWCD_IR_F1_LO];
            end
            o_alu_a_addr <= o_ireg[`MWCD_IR_F1_HI:`MWCD_IR_F1_LO];
        end
    end

    // Byte mode gating of ALU and transceivers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_byte_mode <= 1'b0;
            o_upper_we_block <= 1'b0;
            o_upper_y_off <= 1'b0;
            o_pc_hi_oe_n <= 1'b1;
            o_pc_lo_oe_n <= 1'b1;
            o_pc_dir <= MWCD_DIR_TO_MAR;
        end else begin
            o_byte_mode <= i_microword[`MWCD_BIT_BYTE_MODE];
            o_upper_we_block <= i_microword[`MWCD_BIT_BYTE_MODE];
            o_upper_y_off <= i_microword[`MWCD_BIT_BYTE_MODE];
            o_pc_hi_oe_n <= i_microword[`MWCD_BIT_PC_OFF];
            o_pc_lo_oe_n <= i_microword[`MWCD_BIT_PC_OFF]
                          | i_microword[`MWCD_BIT_BYTE_MODE];
            o_pc_dir <= i_microword[`MWCD_BIT_PC_TO_Y] ? MWCD_DIR_TO_Y
                                                       : MWCD_DIR_TO_MAR;
        end
    end

    // DA bus drive enables; Z0 drive is active low in the word
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_transfer_reg_drive <= 1'b0;
            o_z0_to_da_drive <= 1'b0;
        end else begin
            o_transfer_reg_drive <= i_microword[`MWCD_BIT_TREG_DRIVE];
            o_z0_to_da_drive <= !i_microword[`MWCD_BIT_Z0_DRIVE_N];
        end
    end

    // Control byte consumers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_io_ctl <= `MWCD_ZERO8;
            o_shift_link_strobe <= 1'b0;
            o_shift_link_ctl <= 5'h00;
        end else begin
            if (mw[`MWCD_BIT_IO_LOAD]) begin
                o_io_ctl <= ctl;
            end
            o_shift_link_strobe <= i_microword[`MWCD_BIT_SHIFT_EN];
            o_shift_link_ctl <= i_microword[`MWCD_CTL_LO+4:`MWCD_CTL_LO];
        end
    end

    // Z to Z1 at the start of the cycle that carries the bit
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_z1 <= `MWCD_ZERO16;
        end else if (i_microword[`MWCD_BIT_Z_TO_Z1]) begin
            o_z1 <= i_z_prefetch;
        end
    end

    // Data-side loads act at the end of the cycle, when Y has settled
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_transfer_reg <= `MWCD_ZERO16;
            o_data_reg <= `MWCD_ZERO16;
        end else begin
            if (mw[`MWCD_BIT_TREG_LOAD]) begin
                o_transfer_reg <= i_y_bus;
            end
            if (mw[`MWCD_BIT_D_LOAD]) begin
                o_data_reg <= i_y_bus;
            end
        end
    end

    // Address source: Y when transceivers face the address register
    always_comb begin
        mar_src = i_y_bus;
        if (!mw[`MWCD_BIT_PC_OFF] && mw[`MWCD_BIT_PC_TO_Y]) begin
            mar_src = i_pc_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_memory_address_reg <= `MWCD_ZERO16;
        end else if (mw[`MWCD_BIT_MAR_LOAD]) begin
            o_memory_address_reg <= mar_src;
        end
    end

    // Instruction register and its counter field
    mwcd_ir_counter u_ir (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_load(mw[`MWCD_BIT_Z1_TO_I]),
        .i_count_en(mw[`MWCD_BIT_CNT_EN]),
        .i_count_up(mw[`MWCD_BIT_CNT_UP]),
        .i_z1(o_z1),
        .o_ireg(o_ireg)
    );

    // Checks
    property p_cc_gate;
        @(posedge i_clk) disable iff (!i_reset_n)
        1'b1 |=> o_cond_code_gate == $past(i_microword[`MWCD_BIT_CC_GATE]);
    endproperty
    a_cc_gate: assert property (p_cc_gate) else $error("cc gate mismatch");

    property p_nac;
        @(posedge i_clk) disable iff (!i_reset_n)
        1'b1 |=> o_next_addr_code == $past(i_microword[19:16]);
    endproperty
    a_nac: assert property (p_nac) else $error("next code mismatch");

    property p_jump;
        @(posedge i_clk) disable iff (!i_reset_n)
        1'b1 |=> o_jump_addr == $past(i_microword[11:0]);
    endproperty
    a_jump: assert property (p_jump) else $error("jump address mismatch");

    property p_rom_addr;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_microword[47] |=> o_alu_b_addr == $past(i_microword[42:39])
                         && o_alu_a_addr == $past(i_microword[38:35]);
    endproperty
    a_rom_addr: assert property (p_rom_addr) else $error("control byte address wrong");

    property p_io;
        @(posedge i_clk) disable iff (!i_reset_n)
        mw[46] |=> o_io_ctl == $past(mw[42:35]);
    endproperty
    a_io: assert property (p_io) else $error("io control not loaded");

    property p_byte;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_microword[90] |=> o_upper_we_block && o_upper_y_off && o_pc_lo_oe_n;
    endproperty
    a_byte: assert property (p_byte) else $error("byte mode gating missing");

    property p_pc_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_microword[73] |=> o_pc_hi_oe_n && o_pc_lo_oe_n;
    endproperty
    a_pc_off: assert property (p_pc_off) else $error("transceivers not off");

    property p_treg;
        @(posedge i_clk) disable iff (!i_reset_n)
        mw[76] |=> o_transfer_reg == $past(i_y_bus);
    endproperty
    a_treg: assert property (p_treg) else $error("transfer register not loaded");

    property p_count;
        @(posedge i_clk) disable iff (!i_reset_n)
        mw[75] && !mw[69] && mw[74] |=> o_ireg[14:7] == 8'($past(o_ireg[14:7]) + 8'h01);
    endproperty
    a_count: assert property (p_count) else $error("counter did not step up");

    property p_z0;
        @(posedge i_clk) disable iff (!i_reset_n)
        !i_microword[68] |=> o_z0_to_da_drive;
    endproperty
    a_z0: assert property (p_z0) else $error("z0 drive missing");

    property p_route;
        @(posedge i_clk) disable iff (!i_reset_n)
        !i_microword[`MWCD_BIT_ROM_SEL] && i_microword[`MWCD_BIT_ROUTE_B]
            |=> o_alu_b_addr == $past(o_ireg[`MWCD_IR_F2_HI:`MWCD_IR_F2_LO]);
    endproperty
    a_route: assert property (p_route) else $error("second field not routed to b");

    property p_z1;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_microword[`MWCD_BIT_Z_TO_Z1] |=> o_z1 == $past(i_z_prefetch);
    endproperty
    a_z1: assert property (p_z1) else $error("z1 not loaded from prefetch");

    property p_dreg;
        @(posedge i_clk) disable iff (!i_reset_n)
        mw[`MWCD_BIT_D_LOAD] |=> o_data_reg == $past(i_y_bus);
    endproperty
    a_dreg: assert property (p_dreg) else $error("data register not loaded");

    property p_ir_load;
        @(posedge i_clk) disable iff (!i_reset_n)
        mw[`MWCD_BIT_Z1_TO_I] |=> o_ireg == $past(o_z1);
    endproperty
    a_ir_load: assert property (p_ir_load) else $error("ireg not loaded from z1");

    c_byte: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_byte_mode);
    c_count: cover property (@(posedge i_clk) disable iff (!i_reset_n) mw[75] && !mw[74]);
    c_io: cover property (@(posedge i_clk) disable iff (!i_reset_n) mw[46]);
    c_route: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        i_microword[`MWCD_BIT_ROUTE_B] && !i_microword[`MWCD_BIT_ROM_SEL]);
endmodule // mwcd_decode
`default_nettype wire

/* File: testbench/mwcd_datapath_model.sv */
// Datapath model: Y bus, Z prefetch and PC unit values for the decoder.
// Assumes one clock; values change every cycle after reset.
`timescale 1ns/1ps
`default_nettype none
module mwcd_datapath_model
    import mwcd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Datapath values
    output mwcd_data_t o_y_bus,
    output mwcd_data_t o_z_prefetch,
    output mwcd_data_t o_pc_data
);
    logic [7:0] cnt;
    // New values each cycle, so a late or early capture is caught
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    // Z nibbles always differ, so the two register fields can be told apart
    assign o_y_bus = {cnt ^ 8'hA5, ~cnt};
    assign o_z_prefetch = {cnt ^ 8'h3C, cnt[3:0] ^ 4'h9, cnt[3:0]};
    assign o_pc_data = {~cnt, cnt ^ 8'h5A};
endmodule // mwcd_datapath_model
`default_nettype wire

/* File: testbench/microword_control_decode_tb.sv */
// Self-checking bench for the microword control decoder.
// Assumes the datapath model drives Y, Z and PC values every cycle.
`timescale 1ns/1ps
`default_nettype none
module microword_control_decode_tb
    import mwcd_pkg::*;
;
    logic i_clk, i_reset_n;
    mwcd_word_t i_microword, pw;
    mwcd_data_t i_y_bus, i_z_prefetch, i_pc_data, etr, ez1, eir, emar, ed;
    mwcd_data_t o_transfer_reg, o_z1, o_ireg, o_memory_address_reg, o_data_reg;
    logic [7:0] o_io_ctl, eio;
    logic [11:0] o_jump_addr;
    logic [8:0] o_alu_func;
    logic [4:0] o_shift_link_ctl;
    logic [3:0] o_next_addr_code, o_alu_a_addr, o_alu_b_addr;
    logic o_cond_code_gate, o_byte_mode, o_upper_we_block, o_upper_y_off;
    logic o_alu_source_select, o_alu_y_output_en, o_alu_b_output_en;
    logic o_shift_link_strobe, o_transfer_reg_drive, o_z0_to_da_drive;
    logic o_pc_hi_oe_n, o_pc_lo_oe_n;
    mwcd_dir_e o_pc_dir;
    int fails, n_tests;
    int cyc = 0;

    mwcd_decode DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_microword(i_microword),
        .i_y_bus(i_y_bus), .i_z_prefetch(i_z_prefetch), .i_pc_data(i_pc_data),
        .o_cond_code_gate(o_cond_code_gate), .o_next_addr_code(o_next_addr_code),
        .o_jump_addr(o_jump_addr), .o_alu_a_addr(o_alu_a_addr), .o_alu_b_addr(o_alu_b_addr),
        .o_byte_mode(o_byte_mode), .o_upper_we_block(o_upper_we_block),
        .o_upper_y_off(o_upper_y_off), .o_alu_source_select(o_alu_source_select),
        .o_alu_y_output_en(o_alu_y_output_en), .o_alu_b_output_en(o_alu_b_output_en),
        .o_alu_func(o_alu_func), .o_io_ctl(o_io_ctl), .o_shift_link_strobe(o_shift_link_strobe),
        .o_shift_link_ctl(o_shift_link_ctl), .o_transfer_reg(o_transfer_reg),
        .o_transfer_reg_drive(o_transfer_reg_drive), .o_z0_to_da_drive(o_z0_to_da_drive),
        .o_z1(o_z1), .o_ireg(o_ireg), .o_memory_address_reg(o_memory_address_reg),
        .o_data_reg(o_data_reg), .o_pc_hi_oe_n(o_pc_hi_oe_n), .o_pc_lo_oe_n(o_pc_lo_oe_n),
        .o_pc_dir(o_pc_dir));
    mwcd_datapath_model u_model (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .o_y_bus(i_y_bus), .o_z_prefetch(i_z_prefetch), .o_pc_data(i_pc_data));

    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Cycle bound cuts a hung run short
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            fails++;
            report_and_stop();
        end
    end

    function automatic mwcd_word_t on(input int b);
        return mwcd_word_t'(1) << b;
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One word per cycle; entered just after an edge. Y, Z, PC seen now are
    // what the design samples at the coming edge, so loads are predicted here.
    task automatic step(input mwcd_word_t w);
        i_microword = w;
        if (pw[76]) etr = i_y_bus;
        if (pw[70]) ed = i_y_bus;
        if (pw[71]) emar = (!pw[73] && pw[72]) ? i_pc_data : i_y_bus;
        if (pw[69]) eir = ez1;
        else if (pw[75]) eir[14:7] = pw[74] ? eir[14:7] + 8'h01 : eir[14:7] - 8'h01;
        if (pw[46]) eio = pw[42:35];
        if (w[92]) ez1 = i_z_prefetch;
        pw = w;
        @(posedge i_clk);
        #1;
        chk("cc_gate", 16'(o_cond_code_gate), 16'(w[91]));
        chk("nac", 16'(o_next_addr_code), 16'(w[19:16]));
        chk("jump", 16'(o_jump_addr), 16'(w[11:0]));
        chk("byte", 16'({o_byte_mode, o_upper_we_block, o_upper_y_off}),
            16'({3{w[90]}}));
        chk("alu", 16'({o_alu_source_select, o_alu_y_output_en, o_alu_b_output_en,
            o_alu_func}), 16'(w[89:78]));
        chk("shift", 16'({o_shift_link_strobe, o_shift_link_ctl}),
            16'({w[43], w[39:35]}));
        chk("da", 16'({o_transfer_reg_drive, o_z0_to_da_drive}),
            16'({w[77], !w[68]}));
        chk("pc_oe_n", 16'({o_pc_hi_oe_n, o_pc_lo_oe_n}),
            16'({w[73], w[73] | w[90]}));
        chk("pc_dir", 16'(o_pc_dir), 16'(w[72]));
        chk("treg", o_transfer_reg, etr);
        chk("dreg", o_data_reg, ed);
        chk("mar", o_memory_address_reg, emar);
        chk("z1", o_z1, ez1);
        chk("ireg", o_ireg, eir);
        chk("io_ctl", 16'(o_io_ctl), 16'(eio));
        if (w[47]) begin
            chk("ab_addr", 16'({o_alu_b_addr, o_alu_a_addr}), 16'(w[42:35]));
        end
    endtask

    task automatic test_reset();
        chk("rst_oe_n", 16'({o_pc_hi_oe_n, o_pc_lo_oe_n}), 16'h0003);
        chk("rst_dir", 16'(o_pc_dir), 16'(MWCD_DIR_TO_MAR));
        chk("rst_regs", o_transfer_reg | o_z1 | o_ireg | o_data_reg | o_memory_address_reg,
            16'h0000);
        chk("rst_ctl", 16'({o_io_ctl, o_cond_code_gate, o_byte_mode, o_next_addr_code}),
            16'h0000);
        $display("reset test done");
    endtask

    task automatic test_seq();
        for (int i = 0; i < 16; i++) begin
            step((i[0] ? on(91) : '0) | (mwcd_word_t'(i[3:0]) << 16)
                | mwcd_word_t'(12'hFFF >> i));
        end
        $display("sequencer test done");
    endtask

    // Every combination of byte mode and transceiver control, then all ones
    task automatic test_alu();
        for (int i = 0; i < 8; i++) begin
            step((i[0] ? on(90) | on(77) : '0) | (i[1] ? on(73) | on(68) : '0)
                | (i[2] ? on(72) | on(43) : '0) | (mwcd_word_t'(12'hA5C ^ {4{i[2:0]}}) << 78)
                | on(47) | (mwcd_word_t'(8'h1D + 8'(i * 37)) << 35));
        end
        step('1);
        step('0);
        $display("alu test done");
    endtask

    // Back-to-back loads, MEMORY_ADDRESS_REG fed from PC unit then from Y
    task automatic test_loads();
        step(on(92) | on(76) | on(70) | on(71) | on(72) | on(46) | (mwcd_word_t'(8'h96) << 35));
        step(on(69) | on(71) | on(73) | on(72) | on(76));
        step(on(46) | on(70) | (mwcd_word_t'(8'h69) << 35));
        step('0);
        $display("load test done");
    endtask

    // Long enough upward run to cross the wrap of the counter field
    task automatic test_counter();
        step(on(92));
        step(on(69) | on(75));
        for (int i = 0; i < 270; i++) step(on(75) | on(74));
        for (int i = 0; i < 5; i++) step(on(75));
        step(on(74));
        step('0);
        $display("counter test done");
    endtask

    // Ireg-sourced addresses; previous word leaves ireg untouched
    task automatic test_route();
        step('0);
        for (int i = 0; i < 2; i++) begin
            step(i[0] ? on(95) : '0);
            chk("a_ireg", 16'(o_alu_a_addr), 16'(eir[7:4]));
            chk("b_route", 16'(o_alu_b_addr), 16'(i[0] ? eir[3:0] : eir[7:4]));
        end
        $display("route test done");
    endtask

    initial begin
        i_reset_n = 1'b0;
        i_microword = '0;
        pw = '0;
        {etr, ez1, eir, emar, ed, eio} = '0;
        fails = 0;
        n_tests = 0;
        repeat (12) @(posedge i_clk);
        #1;
        test_reset();
        i_reset_n = 1'b1;
        test_seq();
        test_alu();
        test_loads();
        test_counter();
        test_route();
        report_and_stop();
    end
endmodule // microword_control_decode_tb
`default_nettype wire
